// File: hdl/ctl_pipe_consts.svh
// Functional notes
// - read-only flag tells whether the CPU may access the pipe FIFO.
// - flag means rx data readable when direction 0, tx space when 1.
// - host mode: writing 1 to setup request sends a setup packet.
// - setup end raises ack or error event and clears request in the same cycle.
// - split clear with status already 0 leaves status at 0.
// - complete-split end clears status; software clear only after stop or detach; the code takes the clear at any time in host mode.
// - host mode: split status 1 during complete-split, else 0.
// - writing 1 to toggle clear makes next expected toggle DATA0.
// - writing 1 to toggle set makes next expected toggle DATA1.
// - read-only monitor bit shows next expected toggle.
// - busy flag shows whether pipe activity has settled to NAK.
// - host mode: ping enable 1 allows PING tokens, 0 disables them.
// - peripheral mode: writing 1 to transfer end enable completes status stage.
// - response field: 00 NAK, 01 buffer state, 10 and 11 STALL.
// - write-one command bits read back as 0, except setup request, which reads its pending state.
// - toggle flips after each normal transaction, not on data PID mismatch.
// - busy rises when a pipe transaction starts, falls when it completes.
`ifndef CTL_PIPE_CONSTS_SVH
`define CTL_PIPE_CONSTS_SVH

// ==================================================
// control register bit positions
`define CPC_FIFO_OK_BIT     15
`define CPC_SETUP_REQ_BIT   14
`define CPC_SPLIT_CLR_BIT   13
`define CPC_SPLIT_STS_BIT   12
`define CPC_SETUP_CAN_BIT   11
`define CPC_TOG_DATA0_BIT   8
`define CPC_TOG_DATA1_BIT   7
`define CPC_TOG_MON_BIT     6
`define CPC_BUSY_BIT        5
`define CPC_PING_BIT        4
`define CPC_XFER_END_BIT    2
`define CPC_RESP_HI         1
`define CPC_RESP_LO         0

// ==================================================
// reset values and encodings
`define CPC_TOGGLE_RESET    1'b1
`define CPC_RESP_NAK        2'b00
`define CPC_RESP_BUF        2'b01
`define CPC_REG_ZERO        16'h0000

`endif

// File: hdl/ctl_pipe_pkg.sv
package ctl_pipe_pkg;

    typedef logic [15:0] reg16_t;

    typedef struct packed {
        logic expected;
    } toggle_state_t;

    typedef struct packed {
        logic       setup_send_request;
        logic       complete_split_status;
        logic       ping_issue_enable;
        logic       transfer_end_enable;
        logic [1:0] response;
        logic       pipe_busy_state;
        logic       fifo_access_ok;
        logic       setup_ack_event;
        logic       setup_error_event;
        logic       resp_nak;
        logic       resp_buf;
        logic       resp_stall;
        reg16_t     rdata;
    } ctl_state_t;

endpackage

// File: hdl/data_toggle_tracker.sv
`timescale 1ns/1ps
`include "ctl_pipe_consts.svh"

module data_toggle_tracker
(
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // commands and transaction events
    input  wire logic force_data0,
    input  wire logic force_data1,
    input  wire logic txn_ok,
    input  wire logic pid_mismatch,
    // expected toggle
    output logic      expected
);
    import ctl_pipe_pkg::*;

    toggle_state_t state_reg;
    toggle_state_t state_next;

    always_comb
    begin
        state_next = state_reg;
        if (txn_ok && !pid_mismatch)
        begin
            state_next.expected = ~state_reg.expected;
        end
        // explicit commands override a same-cycle advance
        // force DATA0
        if (force_data0)
        begin
            state_next.expected = 1'b0;
        end
        else if (force_data1)
        begin
            state_next.expected = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg.expected <= `CPC_TOGGLE_RESET;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign expected = state_reg.expected;

    AST_TOGGLE_MISMATCH_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
        (txn_ok && pid_mismatch && !force_data0 && !force_data1)
        |=> (expected == $past(expected)))
        else $error("toggle moved on data PID mismatch");

endmodule

// File: hdl/ctl_pipe_ctrl.sv
`timescale 1ns/1ps
`include "ctl_pipe_consts.svh"

module ctl_pipe_ctrl
(
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    // register port
    input  wire logic                  reg_wr,
    input  wire ctl_pipe_pkg::reg16_t  reg_wdata,
    output ctl_pipe_pkg::reg16_t       reg_rdata,
    // mode and buffer state
    input  wire logic                  host_mode,
    input  wire logic                  pipe_direction_select,
    input  wire logic                  rx_data_ready,
    input  wire logic                  tx_space_ready,
    // link events
    input  wire logic                  setup_done_ok,
    input  wire logic                  setup_done_err,
    input  wire logic                  split_start,
    input  wire logic                  split_end,
    input  wire logic                  txn_start,
    input  wire logic                  txn_done,
    input  wire logic                  txn_ok,
    input  wire logic                  pid_mismatch,
    input  wire logic                  setup_received,
    input  wire logic                  status_stage_done,
    // link controls
    output logic                       setup_send_request,
    output logic                       complete_split_status,
    output logic                       ping_issue_enable,
    output logic                       transfer_end_enable,
    output logic                       toggle_monitor,
    output logic                       pipe_busy_flag,
    output logic                       fifo_access_ok,
    output logic                       resp_nak,
    output logic                       resp_buf,
    output logic                       resp_stall,
    output logic                       setup_ack_event,
    output logic                       setup_error_event
);
    import ctl_pipe_pkg::*;

    ctl_state_t state_reg;
    ctl_state_t state_next;
    logic       toggle_q;
    logic       wr_setup;
    logic       wr_split_clr;
    logic       wr_setup_can;
    logic       wr_tog0;
    logic       wr_tog1;
    logic       wr_xfer_end;
    logic       setup_done;

    // ==================================================
    // write-one command decode
    // zero writes ignored
    assign wr_setup     = reg_wr && reg_wdata[`CPC_SETUP_REQ_BIT];
    assign wr_split_clr = reg_wr && reg_wdata[`CPC_SPLIT_CLR_BIT] && host_mode;
    assign wr_setup_can = reg_wr && reg_wdata[`CPC_SETUP_CAN_BIT] && host_mode;
    assign wr_tog0      = reg_wr && reg_wdata[`CPC_TOG_DATA0_BIT];
    assign wr_tog1      = reg_wr && reg_wdata[`CPC_TOG_DATA1_BIT];
    assign wr_xfer_end  = reg_wr && reg_wdata[`CPC_XFER_END_BIT] && !host_mode;
    assign setup_done   = state_reg.setup_send_request && (setup_done_ok || setup_done_err);

    // ==================================================
    // toggle tracking; a received setup packet primes DATA1 in peripheral mode
    data_toggle_tracker u_toggle
    (
        .clk          (clk),
        .rst_n        (rst_n),
        .force_data0  (wr_tog0),
        .force_data1  (wr_tog1 || (setup_received && !host_mode)),
        .txn_ok       (txn_ok),
        .pid_mismatch (pid_mismatch),
        .expected     (toggle_q)
    );

    // ==================================================
    // next state
    always_comb
    begin
        state_next = state_reg;
        state_next.setup_ack_event   = 1'b0;
        state_next.setup_error_event = 1'b0;

        if (setup_done)
        begin
            state_next.setup_send_request = 1'b0;
            state_next.setup_ack_event    = setup_done_ok;
            state_next.setup_error_event  = !setup_done_ok;
        end
        if (wr_setup_can)
        begin
            state_next.setup_send_request = 1'b0;
        end
        // request setup, host only; a fresh request beats completion
        else if (wr_setup && host_mode)
        begin
            state_next.setup_send_request = 1'b1;
        end

        if (split_end)
        begin
            state_next.complete_split_status = 1'b0;
        end
        if (wr_split_clr)
        begin
            state_next.complete_split_status = 1'b0;
        end
        if (split_start && host_mode)
        begin
            state_next.complete_split_status = 1'b1;
        end

        if (reg_wr)
        begin
            state_next.ping_issue_enable = reg_wdata[`CPC_PING_BIT];
            state_next.response          = reg_wdata[`CPC_RESP_HI:`CPC_RESP_LO];
        end

        // transfer end enable; new setup or stage end retires it
        if (setup_received || status_stage_done)
        begin
            state_next.transfer_end_enable = 1'b0;
        end
        if (wr_xfer_end)
        begin
            state_next.transfer_end_enable = 1'b1;
        end

        if (txn_done)
        begin
            state_next.pipe_busy_state = 1'b0;
        end
        if (txn_start)
        begin
            state_next.pipe_busy_state = 1'b1;
        end

        state_next.fifo_access_ok = pipe_direction_select ? tx_space_ready : rx_data_ready;

        state_next.resp_nak   = (state_next.response == `CPC_RESP_NAK);
        state_next.resp_buf   = (state_next.response == `CPC_RESP_BUF);
        state_next.resp_stall = state_next.response[`CPC_RESP_HI];

        state_next.rdata = `CPC_REG_ZERO;
        state_next.rdata[`CPC_FIFO_OK_BIT]   = state_reg.fifo_access_ok;
        state_next.rdata[`CPC_SETUP_REQ_BIT] = state_reg.setup_send_request;
        // split status only means something in host mode
        state_next.rdata[`CPC_SPLIT_STS_BIT] = state_reg.complete_split_status && host_mode;
        state_next.rdata[`CPC_TOG_MON_BIT]   = toggle_q;
        state_next.rdata[`CPC_BUSY_BIT]      = state_reg.pipe_busy_state;
        state_next.rdata[`CPC_PING_BIT]      = state_reg.ping_issue_enable;
        state_next.rdata[`CPC_RESP_HI:`CPC_RESP_LO] = state_reg.response;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg                       <= '0;
            state_reg.resp_nak              <= 1'b1;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // ==================================================
    // outputs; setup request and split status are gated by host mode where they are set, ping enable is not
    assign reg_rdata             = state_reg.rdata;
    assign setup_send_request    = state_reg.setup_send_request;
    assign complete_split_status = state_reg.complete_split_status;
    assign ping_issue_enable     = state_reg.ping_issue_enable;
    assign transfer_end_enable   = state_reg.transfer_end_enable;
    assign toggle_monitor        = toggle_q;
    assign pipe_busy_flag        = state_reg.pipe_busy_state;
    assign fifo_access_ok        = state_reg.fifo_access_ok;
    assign resp_nak              = state_reg.resp_nak;
    assign resp_buf              = state_reg.resp_buf;
    assign resp_stall            = state_reg.resp_stall;
    assign setup_ack_event       = state_reg.setup_ack_event;
    assign setup_error_event     = state_reg.setup_error_event;

    // ==================================================
    // checks
    AST_SETUP_SET: assert property (@(posedge clk) disable iff (!rst_n)
        (reg_wr && reg_wdata[`CPC_SETUP_REQ_BIT] && host_mode && !wr_setup_can)
        |=> setup_send_request)
        else $error("setup request not taken");
    AST_SETUP_DONE: assert property (@(posedge clk) disable iff (!rst_n)
        (setup_done && !wr_setup && !wr_setup_can)
        |=> (!setup_send_request && (setup_ack_event ^ setup_error_event)))
        else $error("setup completion wrong");
    AST_SETUP_CANCEL: assert property (@(posedge clk) disable iff (!rst_n)
        wr_setup_can |=> !setup_send_request)
        else $error("setup cancel ignored");
    AST_SPLIT_CLEAR: assert property (@(posedge clk) disable iff (!rst_n)
        (wr_split_clr && !split_start) |=> !complete_split_status)
        else $error("split clear ignored");
    AST_SPLIT_SET: assert property (@(posedge clk) disable iff (!rst_n)
        (split_start && host_mode) |=> complete_split_status)
        else $error("split status not set");
    AST_TOG0: assert property (@(posedge clk) disable iff (!rst_n)
        wr_tog0 |=> (!toggle_monitor ##1 (reg_rdata[`CPC_TOG_MON_BIT] == 1'b0)))
        else $error("toggle clear failed");
    AST_TOG1: assert property (@(posedge clk) disable iff (!rst_n)
        (wr_tog1 && !wr_tog0) |=> toggle_monitor)
        else $error("toggle set failed");
    AST_BUSY: assert property (@(posedge clk) disable iff (!rst_n)
        (txn_done && !txn_start) |=> !pipe_busy_flag)
        else $error("busy not dropped");
    AST_RESP: assert property (@(posedge clk) disable iff (!rst_n)
        (reg_wr && reg_wdata[`CPC_RESP_HI]) |=> (resp_stall && !resp_nak && !resp_buf))
        else $error("stall decode wrong");
    AST_CMD_READ_ZERO: assert property (@(posedge clk) disable iff (!rst_n)
        (reg_rdata[`CPC_SETUP_CAN_BIT] == 1'b0) && (reg_rdata[`CPC_SPLIT_CLR_BIT] == 1'b0)
        && (reg_rdata[`CPC_TOG_DATA0_BIT] == 1'b0) && (reg_rdata[`CPC_XFER_END_BIT] == 1'b0)
        && (reg_rdata[`CPC_TOG_DATA1_BIT] == 1'b0))
        else $error("command bit read as one");
    AST_XFER_END: assert property (@(posedge clk) disable iff (!rst_n)
        (wr_xfer_end) |=> transfer_end_enable)
        else $error("transfer end enable not set");
    AST_FIFO_OK: assert property (@(posedge clk) disable iff (!rst_n)
        (pipe_direction_select && tx_space_ready) |=> fifo_access_ok)
        else $error("fifo access flag wrong");
    AST_FIFO_RX: assert property (@(posedge clk) disable iff (!rst_n)
        (!pipe_direction_select) |=> (fifo_access_ok == $past(rx_data_ready)))
        else $error("fifo access flag wrong for receive");

endmodule

// File: bench/usb_far_end.sv
`timescale 1ns/1ps

module usb_far_end
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // answer behaviour
    input  wire logic       answer_err,
    input  wire logic       answer_hold,
    input  wire logic [3:0] answer_delay,
    // pipe side
    input  wire logic       setup_send_request,
    output logic            setup_done_ok,
    output logic            setup_done_err,
    output logic            txn_start,
    output logic            txn_done,
    output logic            txn_ok,
    output logic            pid_mismatch,
    output logic            split_start,
    output logic            split_end,
    output logic            setup_received,
    output logic            status_stage_done
);
    logic [6:0] ev;

    assign {status_stage_done, setup_received, split_end, split_start, txn_ok, txn_done,
            txn_start} = ev;

    // ==========
    // setup answer
    // held answers model a device that never replies
    initial
    begin
        ev = 7'h00;
        pid_mismatch = 1'b0;
        setup_done_ok = 1'b0;
        setup_done_err = 1'b0;
        forever
        begin
            @(negedge clk);
            if (rst_n && setup_send_request && !answer_hold)
            begin
                repeat (answer_delay) @(negedge clk);
                setup_done_ok = !answer_err;
                setup_done_err = answer_err;
                @(negedge clk);
                setup_done_ok = 1'b0;
                setup_done_err = 1'b0;
            end
        end
    end

    // ==========
    // link events
    // one-cycle event pulses
    task automatic fire(input int k);
        @(negedge clk);
        ev[k] = 1'b1;
        @(negedge clk);
        ev[k] = 1'b0;
    endtask

    // several pulses in one cycle, mixed by the bench
    task automatic burst(input logic [6:0] v);
        @(negedge clk);
        ev = v;
        @(negedge clk);
        ev = 7'h00;
    endtask

    task automatic end_txn(input logic m);
        @(negedge clk);
        pid_mismatch = m;
        ev[2:1] = 2'h3;
        @(negedge clk);
        ev[2:1] = 2'h0;
        pid_mismatch = 1'b0;
    endtask
endmodule

// File: bench/test_control_pipe_control_logic.sv
`timescale 1ns/1ps

module test_control_pipe_control_logic;
    import ctl_pipe_pkg::*;

    logic        clk, rst_n, reg_wr, host_mode, pipe_direction_select, rx_data_ready;
    logic        tx_space_ready, answer_err, answer_hold;
    logic [3:0]  answer_delay;
    reg16_t      reg_wdata, reg_rdata;
    logic        setup_send_request, complete_split_status, ping_issue_enable;
    logic        transfer_end_enable, toggle_monitor, pipe_busy_flag, fifo_access_ok;
    logic        resp_nak, resp_buf, resp_stall, setup_ack_event, setup_error_event;
    logic        done_ok, done_err, sp_start, sp_end, t_start, t_done, t_ok, pmis;
    logic        su_rx, st_done, m_req, m_split, m_ping, m_te, m_tog, m_busy;
    logic [1:0]  m_resp;
    logic [31:0] seed, obs;
    logic [31:0] exp_q[$];
    logic [1:0]  ev_q[$];
    int          fail_count, n_checks, cycles;

    ctl_pipe_ctrl i_dut (.clk(clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .host_mode(host_mode),
        .pipe_direction_select(pipe_direction_select), .rx_data_ready(rx_data_ready),
        .tx_space_ready(tx_space_ready), .setup_done_ok(done_ok), .setup_done_err(done_err),
        .split_start(sp_start), .split_end(sp_end), .txn_start(t_start), .txn_done(t_done),
        .txn_ok(t_ok), .pid_mismatch(pmis), .setup_received(su_rx),
        .status_stage_done(st_done), .setup_send_request(setup_send_request),
        .complete_split_status(complete_split_status), .ping_issue_enable(ping_issue_enable),
        .transfer_end_enable(transfer_end_enable), .toggle_monitor(toggle_monitor),
        .pipe_busy_flag(pipe_busy_flag), .fifo_access_ok(fifo_access_ok),
        .resp_nak(resp_nak), .resp_buf(resp_buf), .resp_stall(resp_stall),
        .setup_ack_event(setup_ack_event), .setup_error_event(setup_error_event));

    usb_far_end i_far (.clk(clk), .rst_n(rst_n), .answer_err(answer_err),
        .answer_hold(answer_hold), .answer_delay(answer_delay),
        .setup_send_request(setup_send_request), .setup_done_ok(done_ok),
        .setup_done_err(done_err), .txn_start(t_start), .txn_done(t_done), .txn_ok(t_ok),
        .pid_mismatch(pmis), .split_start(sp_start), .split_end(sp_end),
        .setup_received(su_rx), .status_stage_done(st_done));

    assign obs = {6'h00, resp_nak, resp_buf, resp_stall, setup_send_request,
                  complete_split_status, ping_issue_enable, transfer_end_enable,
                  toggle_monitor, pipe_busy_flag, fifo_access_ok, reg_rdata};

    // ==========
    // helpers
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // pins in the upper half, register image in the lower half
    function automatic logic [31:0] expect_word();
        logic f;
        f = pipe_direction_select ? tx_space_ready : rx_data_ready;
        return {6'h00, m_resp == 2'h0, m_resp == 2'h1, m_resp[1], m_req, m_split, m_ping, m_te,
                m_tog, m_busy, f, f, m_req, 1'b0, m_split, 5'h00, m_tog, m_busy, m_ping, 2'h0,
                m_resp};
    endfunction

    task automatic complete_run();
        if (fail_count == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic cmp_word(input logic [31:0] e, input logic [31:0] o);
        n_checks++;
        if (o !== e)
        begin
            fail_count++;
            $display("[FAIL] t=%0t word exp=%h got=%h", $time, e, o);
        end
    endtask

    task automatic cmp_ev(input logic [1:0] e, input logic [1:0] o);
        n_checks++;
        if (o !== e)
        begin
            fail_count++;
            $display("[FAIL] t=%0t event exp=%h got=%h", $time, e, o);
        end
    endtask

    // every write also reloads ping enable and response
    task automatic wr(input reg16_t cmd);
        @(negedge clk);
        reg_wr = 1'b1;
        reg_wdata = cmd | {11'h000, m_ping, 2'h0, m_resp};
        @(negedge clk);
        reg_wr = 1'b0;
    endtask

    // hold stimulus until the watcher has compared
    task automatic chk();
        repeat (2) @(negedge clk);
        exp_q.push_back(expect_word());
        @(negedge clk);
    endtask

    // ==========
    // clock, watcher, watchdog
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    always @(posedge clk)
    begin
        #1;
        if (exp_q.size() > 0)
            cmp_word(exp_q.pop_front(), obs);
        if (setup_ack_event === 1'b1 || setup_error_event === 1'b1)
            cmp_ev(ev_q.size() > 0 ? ev_q.pop_front() : 2'h0,
                   {setup_error_event, setup_ack_event});
        cycles++;
        if (cycles == 2000)
        begin
            fail_count++;
            complete_run();
        end
    end

    // ==========
    // scenarios
    initial
    begin
        {rst_n, reg_wr, reg_wdata, pipe_direction_select, rx_data_ready, tx_space_ready} = '0;
        {answer_err, answer_hold, answer_delay, m_req, m_split, m_ping, m_te, m_busy} = '0;
        {m_resp, fail_count, n_checks, cycles} = '0;
        host_mode = 1'b1;
        m_tog = 1'b1;
        seed = 32'h3be9_3b59;
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
        chk();
        for (int i = 0; i < 4; i++)
        begin
            seed = lfsr(seed);
            pipe_direction_select = i[0];
            rx_data_ready = seed[0];
            tx_space_ready = seed[1];
            chk();
        end
        for (int r = 0; r < 4; r++)
        begin
            seed = lfsr(seed);
            m_resp = r[1:0];
            m_ping = seed[2];
            wr(16'h0000);
            chk();
        end
        m_resp = 2'h0;
        wr(16'h0000);
        seed = lfsr(seed);
        answer_err = seed[0];
        answer_delay = seed[4:1];
        ev_q.push_back({seed[0], ~seed[0]});
        wr(16'h4000);
        repeat (18) @(negedge clk);
        chk();
        answer_err = 1'b1;
        answer_delay = 4'hc;
        ev_q.push_back(2'h2);
        wr(16'h4000);
        m_req = 1'b1;
        chk();
        repeat (14) @(negedge clk);
        m_req = 1'b0;
        chk();
        answer_hold = 1'b1;
        wr(16'h4000);
        m_req = 1'b1;
        chk();
        wr(16'h0800);
        m_req = 1'b0;
        chk();
        answer_hold = 1'b0;
        answer_err = 1'b0;
        i_far.fire(3);
        m_split = 1'b1;
        chk();
        wr(16'h2000);
        m_split = 1'b0;
        chk();
        wr(16'h2000);
        chk();
        i_far.fire(3);
        i_far.fire(4);
        chk();
        wr(16'h0100);
        m_tog = 1'b0;
        chk();
        wr(16'h0000);
        chk();
        i_far.fire(0);
        m_busy = 1'b1;
        chk();
        i_far.end_txn(1'b0);
        m_busy = 1'b0;
        m_tog = 1'b1;
        chk();
        i_far.fire(0);
        i_far.end_txn(1'b1);
        chk();
        for (int j = 0; j < 6; j++)
        begin
            seed = lfsr(seed);
            i_far.burst(seed[6:0]);
            m_split = seed[3] | (m_split & ~seed[4]);
            m_busy = seed[0] | (m_busy & ~seed[1]);
            m_tog = m_tog ^ seed[2];
            chk();
        end
        i_far.burst(7'h12);
        m_split = 1'b0;
        m_busy = 1'b0;
        m_tog = 1'b1;
        wr(16'h0100);
        wr(16'h0080);
        chk();
        wr(16'h0004);
        chk();
        host_mode = 1'b0;
        wr(16'h4000);
        chk();
        wr(16'h0004);
        m_te = 1'b1;
        chk();
        i_far.fire(6);
        m_te = 1'b0;
        chk();
        wr(16'h0004);
        wr(16'h0100);
        m_te = 1'b1;
        m_tog = 1'b0;
        chk();
        i_far.fire(5);
        m_te = 1'b0;
        m_tog = 1'b1;
        chk();
        m_resp = 2'h3;
        wr(16'h0100);
        rst_n = 1'b0;
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        {m_resp, m_ping} = '0;
        chk();
        repeat (4) @(negedge clk);
        if (ev_q.size() != 0)
            fail_count++;
        complete_run();
    end
endmodule
